// ===== rtl/dit_top.sv
// display interface timing: parallel access clocking, panel sequencing, serial link
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module dit_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire dit_pkg::dit_bus_s bus,
  output logic [31:0] rdData,
  input wire logic [15:0] parDataIn,
  output dit_pkg::dit_par_s parPins,
  output dit_pkg::dit_pan_s panelPins,
  input wire logic serialDataIn,
  output dit_pkg::dit_ser_s serialPins
);
  // registered and next state
  dit_pkg::dit_state_s s;
  dit_pkg::dit_state_s n;

  // header bit: preamble msb first, then read/write and select
  function automatic logic hdrBit(
    input logic [4:0] idx,
    input dit_pkg::dit_ctrl_s c,
    input logic [15:0] pre,
    input logic rw,
    input logic rs
  );
    logic [4:0] j;
    logic bothIn;
    j = idx - {1'b0, c.preLen};
    // select travels in the frame only for three and four wire
    bothIn = c.rwEn && !c.serMode[1];
    if (idx < {1'b0, c.preLen}) begin
      hdrBit = pre[c.preLen - 4'h1 - idx[3:0]];
    end else if (bothIn) begin
      hdrBit = ((j == 5'h00) == c.rwFirst) ? rw : rs;
    end else begin
      hdrBit = c.rwEn ? rw : rs;
    end
  endfunction : hdrBit

  // next-state logic for every engine
  always_comb begin
    logic [9:0] refW;
    logic [9:0] perW;
    logic [9:0] upW;
    logic [9:0] dnW;
    logic [4:0] hdrLen;
    logic rsIn;
    logic serAct;
    dit_pkg::dit_sreq_s req;
    n = s;
    // every local gets a value before any branch reads it
    upW = '0;
    dnW = '0;
    serAct = 1'b0;
    refW = {2'h0, s.refP};
    perW = {2'h0, s.isRead ? s.rd.period : s.wr.period};
    req = dit_pkg::dit_sreq_s'(bus.wdata);
    rsIn = !s.ctrl.serMode[1];
    hdrLen = {1'b0, s.ctrl.preLen} + {4'h0, s.ctrl.rwEn} + {4'h0, rsIn};
    // pin inputs, second stage is the only one read
    n.dIn1 = parDataIn;
    n.dIn2 = s.dIn1;
    n.sIn1 = serialDataIn;
    n.sIn2 = s.sIn1;
    // register writes
    n.rdata = '0;
    if (bus.wr) begin
      if (bus.addr == dit_pkg::OFF_REF) begin
        n.refP = bus.wdata[7:0];
      end else if (bus.addr == dit_pkg::OFF_WR) begin
        n.wr = bus.wdata[23:0];
      end else if (bus.addr == dit_pkg::OFF_RD) begin
        n.rd = bus.wdata;
      end else if (bus.addr == dit_pkg::OFF_CTRL) begin
        n.ctrl = bus.wdata;
      end else if (bus.addr == dit_pkg::OFF_PDAT) begin
        n.pdat = bus.wdata[15:0];
      end else if (bus.addr == dit_pkg::OFF_PAN1) begin
        n.pan1 = bus.wdata;
      end else if (bus.addr == dit_pkg::OFF_PAN2) begin
        n.pan2 = bus.wdata;
      end else if (bus.addr == dit_pkg::OFF_PRE) begin
        n.pre = bus.wdata[15:0];
      end else if (bus.addr == dit_pkg::OFF_SDAT) begin
        // also refills the next burst word while busy
        n.txWord = req.data;
      end
    end
    // read mux, data stands the following cycle only
    if (bus.rd) begin
      if (bus.addr == dit_pkg::OFF_REF) begin
        n.rdata = {24'h000000, s.refP};
      end else if (bus.addr == dit_pkg::OFF_WR) begin
        n.rdata = {8'h00, s.wr};
      end else if (bus.addr == dit_pkg::OFF_RD) begin
        n.rdata = s.rd;
      end else if (bus.addr == dit_pkg::OFF_CTRL) begin
        n.rdata = s.ctrl;
      end else if (bus.addr == dit_pkg::OFF_PDAT) begin
        n.rdata = {16'h0000, s.pdat};
      end else if (bus.addr == dit_pkg::OFF_PAN1) begin
        n.rdata = s.pan1;
      end else if (bus.addr == dit_pkg::OFF_PAN2) begin
        n.rdata = s.pan2;
      end else if (bus.addr == dit_pkg::OFF_PRE) begin
        n.rdata = {16'h0000, s.pre};
      end else if (bus.addr == dit_pkg::OFF_STAT) begin
        // live busy flags and last captured data
        n.rdata = {s.accSt != dit_pkg::A_IDLE, s.serSt != dit_pkg::S_IDLE, 6'h00,
                   s.serRx, s.parRx};
      end
    end
    // parallel access engine; elapsed time counts in ns
    case (s.accSt)
      dit_pkg::A_IDLE: begin
        if (bus.wr && bus.addr == dit_pkg::OFF_GO && bus.wdata[dit_pkg::GO_START]) begin
          n.accSt = dit_pkg::A_RUN;
          n.elap = '0;
          n.isRead = bus.wdata[dit_pkg::GO_READ];
          n.waitLeft = s.ctrl.waitSt;
          n.sampled = 1'b0;
          n.par.data = s.pdat;
        end
      end
      dit_pkg::A_RUN: begin
        n.elap = s.elap + refW;
        // first cycle whose elapsed time reaches the sample point
        if (s.isRead && !s.sampled && s.elap >= {2'h0, s.rd.sample}) begin
          n.parRx = s.dIn2;
          n.sampled = 1'b1;
        end
        if (s.elap + refW >= perW) begin
          n.elap = '0;
          if (s.isRead && s.waitLeft != 2'h0) begin
            n.waitLeft = s.waitLeft - 2'h1;
          end else if (s.ctrl.single) begin
            n.accSt = dit_pkg::A_GAP;
          end else begin
            n.accSt = dit_pkg::A_IDLE;
          end
        end
      end
      dit_pkg::A_GAP: begin
        // one full interface period with every control idle
        n.elap = s.elap + refW;
        if (s.elap + refW >= perW) begin
          n.elap = '0;
          n.accSt = dit_pkg::A_IDLE;
        end
      end
      default: begin
        n.accSt = dit_pkg::A_IDLE;
      end
    endcase
    // edges land on whole reference cycles: ceil of time over period
    upW = {2'h0, n.isRead ? s.rd.upT : s.wr.upT};
    dnW = {2'h0, n.isRead ? s.rd.downT : s.wr.downT};
    n.par.csN = (n.accSt != dit_pkg::A_RUN);
    n.par.clk = !(n.accSt == dit_pkg::A_RUN && n.elap >= upW && n.elap < dnW);
    n.par.rw = n.isRead;
    n.par.oe = (n.accSt == dit_pkg::A_RUN) && !n.isRead;
    // panel sequencer, one pixel every pixDiv+1 cycles
    if (!s.ctrl.panelEn) begin
      n.divCnt = '0;
      n.pixCnt = '0;
      n.pan = dit_pkg::RST_PANEL;
    end else if (s.divCnt == s.pan2.pixDiv) begin
      n.divCnt = '0;
      n.pixCnt = (s.pixCnt == s.pan2.lineLen) ? 8'h00 : s.pixCnt + 8'h01;
      // width is one pixel by construction, not programmable
      n.pan.ssp = (n.pixCnt == s.pan1.hStart - 8'h01);
      if (n.pixCnt == s.pan1.gateUp) begin
        n.pan.gate = 1'b1;
      end else if (n.pixCnt == s.pan1.gateDown) begin
        n.pan.gate = 1'b0;
      end
      if (n.pixCnt == s.pan2.psDrop) begin
        n.pan.ps = 1'b0;
      end else if (n.pixCnt == s.pan2.psRaise) begin
        n.pan.ps = 1'b1;
      end
      if (n.pixCnt == s.pan1.invDelay) begin
        n.pan.inv = !s.pan.inv;
      end
    end else begin
      n.divCnt = s.divCnt + 8'h01;
    end
    // serial engine, four cycles per bit
    case (s.serSt)
      dit_pkg::S_IDLE: begin
        if (bus.wr && bus.addr == dit_pkg::OFF_SDAT) begin
          n.serSt = dit_pkg::S_SETUP;
          n.rs = req.rs;
          n.rw = req.read;
          n.wordsLeft = s.ctrl.burstLen;
          n.hdrIdx = '0;
          n.bitIdx = '0;
          n.phase = '0;
          n.shift = req.data;
          // select stands before chip select goes active
          if (s.ctrl.serMode == dit_pkg::SM_5W2) begin
            n.ser.rs = req.rs;
          end
        end
      end
      dit_pkg::S_SETUP: begin
        n.serSt = (hdrLen == 5'h00) ? dit_pkg::S_DATA : dit_pkg::S_HEAD;
        if (s.ctrl.serMode == dit_pkg::SM_5W1) begin
          n.ser.rs = s.rs;
        end
      end
      dit_pkg::S_HEAD: begin
        n.phase = s.phase + 2'h1;
        if (s.phase == 2'h3) begin
          if (s.hdrIdx == hdrLen - 5'h01) begin
            n.serSt = dit_pkg::S_DATA;
          end else begin
            n.hdrIdx = s.hdrIdx + 5'h01;
          end
        end
      end
      dit_pkg::S_DATA: begin
        n.phase = s.phase + 2'h1;
        if (s.phase == 2'h3) begin
          // synchroniser delay: picks the level of the low phase
          n.serRx = {s.serRx[6:0], s.sIn2};
          n.shift = {s.shift[6:0], 1'b0};
          n.bitIdx = s.bitIdx + 3'h1;
          if (s.bitIdx == 3'h7) begin
            if (s.wordsLeft != 4'h0) begin
              n.wordsLeft = s.wordsLeft - 4'h1;
              n.shift = s.txWord;
            end else begin
              n.serSt = dit_pkg::S_END;
            end
          end
        end
      end
      dit_pkg::S_END: begin
        n.serSt = dit_pkg::S_IDLE;
        n.ser.rs = 1'b0;
      end
      default: begin
        n.serSt = dit_pkg::S_IDLE;
      end
    endcase
    // serial pins from the next state
    serAct = (n.serSt == dit_pkg::S_HEAD) || (n.serSt == dit_pkg::S_DATA);
    n.ser.cs = s.ctrl.csInv ? serAct : !serAct;
    n.ser.sclk = (serAct && n.phase[1]) ^ s.ctrl.sclkInv;
    n.ser.dout = (n.serSt == dit_pkg::S_HEAD) ?
                 hdrBit(n.hdrIdx, s.ctrl, s.pre, n.rw, n.rs) : n.shift[7];
    // three-wire releases the shared line for read data
    n.ser.oe = (s.ctrl.serMode != dit_pkg::SM_3W) ||
               (serAct && !(n.serSt == dit_pkg::S_DATA && n.rw));
  end

  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.refP <= dit_pkg::RST_REF;
      s.wr <= dit_pkg::RST_WR;
      s.rd <= dit_pkg::RST_RD;
      s.ctrl <= dit_pkg::RST_CTRL;
      s.pan1 <= dit_pkg::RST_PAN1;
      s.pan2 <= dit_pkg::RST_PAN2;
      s.accSt <= dit_pkg::A_IDLE;
      s.par <= dit_pkg::RST_PAR;
      s.pan <= dit_pkg::RST_PANEL;
      s.serSt <= dit_pkg::S_IDLE;
      s.ser <= dit_pkg::RST_SER;
    end else begin
      s <= n;
    end
  end

  // outputs straight from flops
  assign rdData = s.rdata;
  assign parPins = s.par;
  assign panelPins = s.pan;
  assign serialPins = s.ser;

  // helpers for the checks below
  logic [9:0] aRef;
  logic [9:0] aUp;
  logic [9:0] aDn;
  logic [9:0] aPer;
  logic [9:0] aSmp;
  assign aRef = {2'h0, s.refP};
  assign aUp = {2'h0, s.isRead ? s.rd.upT : s.wr.upT};
  assign aDn = {2'h0, s.isRead ? s.rd.downT : s.wr.downT};
  assign aPer = {2'h0, s.isRead ? s.rd.period : s.wr.period};
  assign aSmp = {2'h0, s.rd.sample};

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  AST_DOWN_EDGE:
    assert property (!parPins.csN && $rose(parPins.clk) && s.elap != 10'h000
      |-> s.elap >= aDn && s.elap < aDn + aRef) else $error("down edge misplaced");
  AST_UP_EDGE:
    assert property (!parPins.csN && $fell(parPins.clk)
      |-> s.elap >= aUp && s.elap < aUp + aRef) else $error("up edge misplaced");
  AST_IDLE_HIGH:
    assert property (parPins.csN |-> parPins.clk) else $error("clock low outside access");
  AST_LAUNCH:
    assert property ($fell(parPins.csN) |-> parPins.data == $past(s.pdat))
      else $error("data not launched at start");
  AST_SAMPLE:
    assert property ($rose(s.sampled) |-> $past(s.elap) >= $past(aSmp)
      && $past(s.elap) < $past(aSmp) + $past(aRef)) else $error("read sampled off point");
  AST_GAP:
    assert property (s.ctrl.single && $rose(s.accSt == dit_pkg::A_GAP)
      |-> parPins.csN [*2]) else $error("controls active in gap");
  AST_WAIT:
    assert property (s.accSt == dit_pkg::A_RUN && s.isRead && s.elap + aRef >= aPer
      && s.waitLeft != 2'h0 |=> s.accSt == dit_pkg::A_RUN && s.elap == 10'h000
      && s.waitLeft == $past(s.waitLeft) - 2'h1) else $error("wait state lost");
  AST_SSP:
    assert property (panelPins.ssp |-> s.pixCnt == s.pan1.hStart - 8'h01)
      else $error("start pulse misplaced");
  AST_GATE:
    assert property (s.ctrl.panelEn && $rose(panelPins.gate) |-> s.pixCnt == s.pan1.gateUp)
      else $error("gate clock rise misplaced");
  AST_PS:
    assert property ($fell(panelPins.ps) |-> s.pixCnt == s.pan2.psDrop)
      else $error("power save drop misplaced");
  AST_INV:
    assert property (s.ctrl.panelEn && $changed(panelPins.inv)
      |-> s.pixCnt == s.pan1.invDelay) else $error("inversion toggle misplaced");
  AST_3W_TURN:
    assert property ($stable(s.ctrl) && s.ctrl.serMode == dit_pkg::SM_3W
      && s.serSt == dit_pkg::S_DATA && s.rw |-> !serialPins.oe) else $error("no turnaround");
  AST_4W_OE:
    assert property ($stable(s.ctrl) && s.ctrl.serMode != dit_pkg::SM_3W |-> serialPins.oe)
      else $error("output line released");
  AST_CS_IDLE:
    assert property ($stable(s.ctrl) && s.serSt == dit_pkg::S_IDLE
      |-> serialPins.cs == !s.ctrl.csInv) else $error("chip select polarity wrong");

  COV_WRITE: cover property ($fell(parPins.csN) && !parPins.rw);
  COV_READ_WAIT: cover property (s.isRead && s.waitLeft != 2'h0 ##1 s.waitLeft == 2'h0);
  COV_BURST: cover property (s.bitIdx == 3'h7 && s.phase == 2'h3 && s.wordsLeft != 4'h0);
  COV_SSP: cover property ($rose(panelPins.ssp));
endmodule : dit_top

// ===== rtl/dit_pkg.sv
// package: register map, field layouts, states and pin bundles of the display timing block
// Operation
// - clock down edge at ceil of down-time
// - clock up edge at ceil of up-time
// - clock low from up to down; launch at start
// - separate write and read timing settings
// - single mode: controls idle one period after
// - read stretched by wait states, up to three
// - start pulse fixed one pixel wide
// - gate clock rise and fall delays
// - power save drop and raise delays
// - inversion toggles once per line at delay
// - three-wire and four-wire serial variants
// - two five-wire variants, select sampling differs
// - three-wire output enable steers shared line
// - optional programmable preamble before frame
// - read/write and select bit order programmable
// - read/write bit can be disabled
// - data phase single word or burst
// - four-wire: separate lines, no turnaround
package dit_pkg;
  // clock of the block, also the reference clock
  localparam int CLK_PERIOD_NS = 4;
  // register byte offsets
  localparam logic [7:0] OFF_REF = 8'h00;
  localparam logic [7:0] OFF_WR = 8'h04;
  localparam logic [7:0] OFF_RD = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_GO = 8'h10;
  localparam logic [7:0] OFF_PDAT = 8'h14;
  localparam logic [7:0] OFF_PAN1 = 8'h18;
  localparam logic [7:0] OFF_PAN2 = 8'h1C;
  localparam logic [7:0] OFF_PRE = 8'h20;
  localparam logic [7:0] OFF_SDAT = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  // go register bit positions
  localparam int GO_START = 0;
  localparam int GO_READ = 1;
  // serial variants
  localparam logic [1:0] SM_3W = 2'h0;
  localparam logic [1:0] SM_4W = 2'h1;
  localparam logic [1:0] SM_5W1 = 2'h2;
  localparam logic [1:0] SM_5W2 = 2'h3;
  // reset values
  localparam logic [7:0] RST_REF = 8'(CLK_PERIOD_NS);
  localparam logic [23:0] RST_WR = 24'h0C0410;
  localparam logic [31:0] RST_RD = 32'h0C0C0410;
  localparam logic [31:0] RST_CTRL = 32'h00000100;
  localparam logic [31:0] RST_PAN1 = 32'h40301001;
  localparam logic [31:0] RST_PAN2 = 32'h03FF2010;
  localparam logic [19:0] RST_PAR = 20'hC0000;
  localparam logic [3:0] RST_PANEL = 4'h2;
  localparam logic [4:0] RST_SER = 5'h10;
  // timing in ns: down, up, period
  typedef struct packed {logic [7:0] downT; logic [7:0] upT; logic [7:0] period;} dit_wtim_s;
  typedef struct packed {
    logic [7:0] sample; logic [7:0] downT; logic [7:0] upT; logic [7:0] period;
  } dit_rtim_s;
  // control register layout
  typedef struct packed {
    logic [13:0] pad; logic [3:0] burstLen; logic [3:0] preLen; logic rwFirst; logic rwEn;
    logic [1:0] serMode; logic sclkInv; logic csInv; logic [1:0] waitSt; logic single;
    logic panelEn;
  } dit_ctrl_s;
  // panel delays in pixel clocks; pixDiv in reference cycles
  typedef struct packed {
    logic [7:0] invDelay; logic [7:0] gateDown; logic [7:0] gateUp; logic [7:0] hStart;
  } dit_pan1_s;
  typedef struct packed {
    logic [7:0] pixDiv; logic [7:0] lineLen; logic [7:0] psRaise; logic [7:0] psDrop;
  } dit_pan2_s;
  // serial request word
  typedef struct packed {logic [21:0] pad; logic read; logic rs; logic [7:0] data;} dit_sreq_s;
  // register bus from software
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic wr; logic rd;} dit_bus_s;
  // pin bundles
  typedef struct packed {logic clk; logic csN; logic rw; logic oe; logic [15:0] data;} dit_par_s;
  typedef struct packed {logic ssp; logic gate; logic ps; logic inv;} dit_pan_s;
  typedef struct packed {logic cs; logic sclk; logic dout; logic oe; logic rs;} dit_ser_s;
  // state machines
  typedef enum logic [2:0] {A_IDLE = 3'h1, A_RUN = 3'h2, A_GAP = 3'h4} dit_acc_e;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_SETUP = 5'h02, S_HEAD = 5'h04, S_DATA = 5'h08, S_END = 5'h10
  } dit_ser_e;
  // whole state of the block
  typedef struct packed {
    logic [7:0] refP; dit_wtim_s wr; dit_rtim_s rd; dit_ctrl_s ctrl; dit_pan1_s pan1;
    dit_pan2_s pan2; logic [15:0] pre; logic [31:0] rdata;
    dit_acc_e accSt; logic [9:0] elap; logic isRead; logic [1:0] waitLeft; logic sampled;
    logic [15:0] pdat; logic [15:0] parRx; dit_par_s par;
    logic [15:0] dIn1; logic [15:0] dIn2; logic sIn1; logic sIn2;
    logic [7:0] divCnt; logic [7:0] pixCnt; dit_pan_s pan;
    dit_ser_e serSt; logic [1:0] phase; logic [4:0] hdrIdx; logic [2:0] bitIdx;
    logic [3:0] wordsLeft; logic [7:0] txWord; logic [7:0] shift; logic rs; logic rw;
    logic [7:0] serRx; dit_ser_s ser;
  } dit_state_s;
endpackage : dit_pkg

// ===== tb/dit_display_model.sv
// display-side partner: answers parallel reads and serial reads
`timescale 1ns/1ns
module dit_display_model (
  input wire logic ref_clk,
  input wire dit_pkg::dit_par_s parPins,
  input wire dit_pkg::dit_ser_s serialPins,
  input wire logic csAct,
  input wire logic sclkIdle,
  input wire logic [4:0] hdrBits,
  input wire logic [15:0] parWord,
  input wire logic [7:0] serWord,
  output logic [15:0] parDataIn,
  output logic serOut
);
  logic [5:0] bitCnt; // bits completed in this frame (sclk returns to idle)
  logic prevSclk; // sclk one cycle back
  initial begin
    parDataIn = 16'h0000;
    serOut = 1'b0;
    bitCnt = 6'h00;
    prevSclk = 1'b0;
  end
  // read word only while a read is selected; a released bus keeps moving
  always @(posedge ref_clk) begin
    parDataIn <= (!parPins.csN && parPins.rw) ? parWord : ~parDataIn;
  end
  // new bit each time sclk falls back to idle; answer starts after the header
  always @(posedge ref_clk) begin : serAns
    logic [5:0] n;
    logic [5:0] d;
    n = bitCnt + 6'((prevSclk !== sclkIdle) && (serialPins.sclk === sclkIdle));
    d = n - 6'(hdrBits);
    prevSclk <= serialPins.sclk;
    if (serialPins.cs !== csAct) begin
      bitCnt <= 6'h00;
      serOut <= ~serOut; // not selected: no stale level
    end else begin
      bitCnt <= n;
      serOut <= (n >= 6'(hdrBits)) ? serWord[~d[2:0]] : ~serOut;
    end
  end
endmodule : dit_display_model

// ===== tb/dit_top_tb.sv
// self-checking bench for the display timing block
`timescale 1ns/1ns
module dit_top_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  dit_pkg::dit_bus_s bus = '0;
  logic [31:0] rdData;
  logic [15:0] parDataIn;
  dit_pkg::dit_par_s parPins;
  dit_pkg::dit_pan_s panelPins;
  logic serialDataIn;
  dit_pkg::dit_ser_s serialPins;
  logic modelSer;
  logic csAct = 1'b0; // active level of chip select
  logic sclkIdle = 1'b0; // idle level of serial clock
  logic threeW = 1'b1; // shared data line in use
  logic [4:0] hdrBits = 5'h00;
  logic [15:0] parWord = 16'h0000;
  logic [7:0] serWord = 8'h00;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32'h6B91;
  logic [63:0] expQ[$]; // mask and expected read data
  logic rdPend = 1'b0;
  logic [3:0] hist[$]; // panel pins, one entry a cycle
  logic [7:0] offs[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h3C};
  logic [31:0] rstv[9] = '{32'(dit_pkg::RST_REF), 32'(dit_pkg::RST_WR), dit_pkg::RST_RD,
    dit_pkg::RST_CTRL, 32'h0, dit_pkg::RST_PAN1, dit_pkg::RST_PAN2, 32'h0, 32'h0};
  // 250 MHz
  always #2 ref_clk = ~ref_clk;
  // shared line: design drives when enabled, else the display
  assign serialDataIn = (threeW && serialPins.oe) ? serialPins.dout : modelSer;
  dit_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus), .rdData(rdData),
    .parDataIn(parDataIn), .parPins(parPins), .panelPins(panelPins),
    .serialDataIn(serialDataIn), .serialPins(serialPins));
  dit_display_model model (.ref_clk(ref_clk), .parPins(parPins), .serialPins(serialPins),
    .csAct(csAct), .sclkIdle(sclkIdle), .hdrBits(hdrBits), .parWord(parWord),
    .serWord(serWord), .parDataIn(parDataIn), .serOut(modelSer));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic writeReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask : writeReg
  task automatic readReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    expQ.push_back({m, e});
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
  endtask : readReg
  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    logic [63:0] x;
    if (rdPend) begin
      x = expQ.pop_front();
      check(rdData & x[63:32], x[31:0]);
    end
    rdPend <= bus.rd;
  end
  // one access, cycle by cycle; reference period is 4 ns
  task automatic parAccess(input int per, input int up, input int dn, input int reps,
      input logic rd, input logic [15:0] d);
    int n;
    int e;
    n = (per + 3) / 4;
    for (int k = 0; k < n * reps; k++) begin
      #1;
      e = (k % n) * 4;
      check(32'({parPins.csN, parPins.rw, parPins.oe, parPins.clk}),
        32'({1'b0, rd, !rd, !(e >= up && e < dn)}));
      if (!rd) check(32'(parPins.data), 32'(d));
      @(posedge ref_clk);
    end
    #1;
    check(32'(parPins.csN), 32'h1);
  endtask : parAccess
  function automatic int findEdge(input int b, input logic lvl, input int from);
    for (int c = from + 1; c < hist.size(); c++)
      if (hist[c][b] === lvl && hist[c-1][b] !== lvl) return c;
    return -1000;
  endfunction : findEdge
  // one frame; f is rwEn, rwFirst, csInv, sclkInv
  task automatic serFrame(input logic [1:0] m, input logic [3:0] pl, input logic [15:0] pre,
      input logic [3:0] f, input logic [3:0] bl, input logic rs, input logic rd);
    dit_pkg::dit_ctrl_s c;
    logic [31:0] ex;
    logic [31:0] got;
    logic [7:0] w;
    logic prevRs;
    logic lastSclk;
    logic seen;
    int nb;
    int hb;
    int sh;
    c = '{pad: '0, burstLen: bl, preLen: pl, rwFirst: f[2], rwEn: f[3], serMode: m,
      sclkInv: f[0], csInv: f[1], waitSt: 2'h0, single: 1'b0, panelEn: 1'b0};
    w = 8'($random(seed));
    hb = int'(f[3]) + ((m < 2) ? 1 : 0);
    sh = rd ? 8 : 0;
    ex = 32'h0;
    for (int i = int'(pl) - 1; i >= 0; i--) ex = {ex[30:0], pre[i]};
    if (f[3] && (f[2] || m >= 2)) ex = {ex[30:0], rd};
    if (m < 2) ex = {ex[30:0], rs};
    if (m < 2 && f[3] && !f[2]) ex = {ex[30:0], rd};
    for (int i = 0; i <= int'(bl); i++) ex = {ex[23:0], w};
    writeReg(dit_pkg::OFF_CTRL, 32'(c));
    writeReg(dit_pkg::OFF_PRE, {16'h0000, pre});
    serWord <= 8'($random(seed));
    csAct <= f[1];
    sclkIdle <= f[0];
    threeW <= (m == dit_pkg::SM_3W);
    hdrBits <= 5'(int'(pl) + hb);
    writeReg(dit_pkg::OFF_SDAT, {22'h0, rd, rs, w});
    got = 32'h0;
    nb = 0;
    seen = 1'b0;
    #1;
    prevRs = serialPins.rs;
    lastSclk = f[0];
    for (int t = 0; t < 400; t++) begin
      @(posedge ref_clk);
      #1;
      if (serialPins.cs === f[1]) begin
        if (!seen && m == dit_pkg::SM_5W2) check(32'(prevRs), 32'(rs));
        seen = 1'b1;
        if (serialPins.sclk !== f[0] && lastSclk === f[0]) begin
          got = {got[30:0], serialPins.dout};
          check(32'({serialPins.oe, serialPins.rs}), 32'({!(m == dit_pkg::SM_3W && rd &&
            nb >= hb + int'(pl)), (m >= 2) ? rs : 1'b0}));
          nb++;
        end
      end else if (seen) break;
      prevRs = serialPins.rs;
      lastSclk = serialPins.sclk;
    end
    check(32'(nb), 32'(int'(pl) + hb + 8 * (int'(bl) + 1)));
    check(got >> sh, ex >> sh);
    check(32'({serialPins.sclk, serialPins.cs}), 32'({f[0], ~f[1]}));
    if (rd) readReg(dit_pkg::OFF_STAT, 32'h00FF0000, {8'h00, serWord, 16'h0000});
    $display("serial frame mode %0d done", m);
  endtask : serFrame
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #80000;
    fail_count++;
    $display("watchdog expired");
    summarize();
  end
  initial begin : mainSeq
    logic [31:0] v;
    int s0;
    logic iv;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    foreach (offs[i]) readReg(offs[i], 32'hFFFFFFFF, rstv[i]);
    v = $random(seed);
    writeReg(dit_pkg::OFF_WR, v);
    readReg(dit_pkg::OFF_WR, 32'hFFFFFFFF, {8'h00, v[23:0]});
    writeReg(dit_pkg::OFF_RD, ~v);
    readReg(dit_pkg::OFF_RD, 32'hFFFFFFFF, ~v);
    $display("register test done");
    // write: 18 ns period, up 5, down 13 on odd boundaries to test rounding up
    writeReg(dit_pkg::OFF_REF, 32'h4);
    writeReg(dit_pkg::OFF_WR, 32'h000D0512);
    writeReg(dit_pkg::OFF_RD, 32'h10110918);
    writeReg(dit_pkg::OFF_PDAT, v ^ 32'h5A5A);
    writeReg(dit_pkg::OFF_GO, 32'h1);
    parAccess(18, 5, 13, 1, 1'b0, v[15:0] ^ 16'h5A5A);
    $display("parallel write test done");
    // read with three wait states in single mode; a start in the gap is dropped
    parWord <= 16'($random(seed));
    writeReg(dit_pkg::OFF_CTRL, 32'h10E);
    writeReg(dit_pkg::OFF_GO, 32'h3);
    parAccess(24, 9, 17, 4, 1'b1, 16'h0);
    writeReg(dit_pkg::OFF_GO, 32'h1);
    repeat (12) begin
      @(posedge ref_clk);
      #1;
      check(32'({parPins.csN, parPins.clk}), 32'h3);
    end
    readReg(dit_pkg::OFF_STAT, 32'h0000FFFF, {16'h0000, parWord});
    $display("parallel read test done");
    writeReg(dit_pkg::OFF_PAN1, 32'h050A0604);
    writeReg(dit_pkg::OFF_PAN2, 32'h010F0C06);
    writeReg(dit_pkg::OFF_CTRL, 32'h101);
    repeat (140) begin
      @(posedge ref_clk);
      #1;
      hist.push_back(4'(panelPins));
    end
    // two cycles a pixel, sixteen pixels a line
    s0 = findEdge(3, 1'b1, 40);
    iv = hist[s0][0];
    check(32'(findEdge(3, 1'b0, s0) - s0), 32'h2);
    check(32'(findEdge(3, 1'b1, s0) - s0), 32'h20);
    check(32'(findEdge(2, 1'b1, s0) - s0), 32'h6);
    check(32'(findEdge(2, 1'b0, s0) - s0), 32'hE);
    check(32'(findEdge(1, 1'b0, s0) - s0), 32'h6);
    check(32'(findEdge(1, 1'b1, s0) - s0), 32'h12);
    check(32'(findEdge(0, ~iv, s0) - s0), 32'h4);
    check(32'(findEdge(0, iv, s0 + 4) - s0), 32'h24);
    $display("panel test done");
    serFrame(dit_pkg::SM_3W, 4'h3, 16'h0005, 4'hC, 4'h0, 1'b1, 1'b0);
    serFrame(dit_pkg::SM_3W, 4'h0, 16'h0000, 4'h8, 4'h0, 1'b0, 1'b1);
    serFrame(dit_pkg::SM_4W, 4'h2, 16'h0002, 4'h8, 4'h1, 1'b1, 1'b0);
    serFrame(dit_pkg::SM_4W, 4'h0, 16'h0000, 4'h3, 4'h0, 1'b1, 1'b0);
    serFrame(dit_pkg::SM_5W1, 4'h1, 16'h0001, 4'hC, 4'h0, 1'b1, 1'b0);
    serFrame(dit_pkg::SM_5W2, 4'h0, 16'h0000, 4'h8, 4'h0, 1'b1, 1'b0);
    repeat (4) @(posedge ref_clk);
    summarize();
  end
endmodule : dit_top_tb
